// ==== bench/core_model.sv ====
// Purpose: Processor side that presents accesses to the checker
// Assumes: One access per call, answer one cycle later
// Notes: Released qualifiers show inverted values, never stale ones
module core_model (
  input wire logic aclk,
  output logic acc_valid,
  output logic acc_priv,
  output logic acc_write,
  output logic [7:0] acc_region_hit
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    acc_valid = 1'b0;
    acc_priv = 1'b0;
    acc_write = 1'b0;
    acc_region_hit = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////
  // One access, then release; returns once the answer has settled
  task automatic issue(input logic p, w, input logic [7:0] h);
    @(posedge aclk);
    acc_valid <= 1'b1;
    acc_priv <= p;
    acc_write <= w;
    acc_region_hit <= h;
    @(posedge aclk);
    acc_valid <= 1'b0;
    acc_priv <= ~p;
    acc_write <= ~w;
    acc_region_hit <= ~h;
    #1;
  endtask
endmodule

// ==== bench/mpu_attr_check_bench.sv ====
// Purpose: Self-checking bench for the attribute and permission checker
// Assumes: Register offsets and field layout from the shared package
// Notes: Bus tasks wait on handshakes; a cycle ceiling ends any hang
module mpu_attr_check_bench
  import mpu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic acc_valid, acc_priv, acc_write;
  logic [7:0] acc_region_hit;
  logic resp_valid, resp_fault, resp_hit, resp_shareable;
  logic [2:0] resp_region;
  mem_type_e resp_mem_type;
  logic [1:0] resp_inner_policy, resp_outer_policy;
  logic mm_fault_exc, irq;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  mpu_attr_check mpu_attr_check_i (.*);
  core_model core_model_i (.*);
  always #5 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and hang guard
  task automatic chk(input string nm, input logic [31:0] e, s);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Ceiling sits far above the few hundred cycles the tests need
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Register bus tasks: each channel held until its own ready
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Region setup, access checks and expected permission outcome
  function automatic logic [31:0] aword(input logic [2:0] ap, t, scb);
    return {5'h0, ap, 2'h0, t, scb, 15'h0, 1'b1};
  endfunction
  task automatic cfg(input logic [2:0] n, input logic [31:0] v);
    wr(OFF_REGION_SEL, 32'(n), RESP_OKAY);
    wr(OFF_REGION_ATTR, v, RESP_OKAY);
  endtask
  task automatic acc(input logic p, w, input logic [7:0] h,
                     input logic f, input logic [2:0] rg);
    core_model_i.issue(p, w, h);
    chk("resp_valid", 32'h1, 32'(resp_valid));
    chk("resp_fault", 32'(f), 32'(resp_fault));
    chk("mm_fault_exc", 32'(f), 32'(mm_fault_exc));
    chk("resp_region", 32'(rg), 32'(resp_region));
  endtask
  task automatic attr(input logic [2:0] t, scb, input logic [3:0] ty,
                      input logic sh, input logic [3:0] pol, input logic pn);
    cfg(3'h0, aword(PERM_FULL, t, scb));
    acc(1'b1, 1'b0, 8'h01, 1'b0, 3'h0);
    chk("resp_mem_type", 32'(ty), 32'(resp_mem_type));
    chk("resp_shareable", 32'(sh), 32'(resp_shareable));
    if (pn)
      chk("policy", 32'(pol), {28'h0, resp_inner_policy, resp_outer_policy});
  endtask
  // Reserved code 100 is taken as no access
  function automatic logic pexp(input logic [2:0] ap, input logic p, w);
    case (ap)
      3'h1: return !p;
      3'h2: return !p && w;
      3'h3: return 1'b0;
      3'h5: return !p || w;
      3'h6, 3'h7: return w;
      default: return 1'b1;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++)
      rd(8'(4 * i), RESET_VALUE, RESP_OKAY);
    rd(8'h14, 32'h0, RESP_DECERR);
    wr(8'h14, 32'hffff_ffff, RESP_DECERR);
    // Protection still off, so even a forbidden access passes
    acc(1'b0, 1'b1, 8'h01, 1'b0, 3'h0);
    wr(OFF_CTRL, 32'h1, RESP_OKAY);
    for (int a = 0; a < 8; a++) begin
      cfg(3'h0, aword(3'(a), 3'h0, 3'b010));
      for (int k = 0; k < 4; k++)
        acc(k[1], k[0], 8'h01, pexp(3'(a), k[1], k[0]), 3'h0);
    end
    attr(3'h0, 3'b000, 4'h1, 1'b1, 4'h0, 1'b0);
    attr(3'h0, 3'b101, 4'h2, 1'b1, 4'h0, 1'b0);
    attr(3'h0, 3'b010, 4'h4, 1'b0, 4'ha, 1'b1);
    attr(3'h0, 3'b110, 4'h4, 1'b1, 4'ha, 1'b1);
    attr(3'h0, 3'b111, 4'h4, 1'b1, 4'hf, 1'b1);
    attr(3'h1, 3'b111, 4'h4, 1'b1, 4'h5, 1'b1);
    attr(3'h1, 3'b100, 4'h4, 1'b1, 4'h0, 1'b1);
    attr(3'h1, 3'b001, 4'h8, 1'b0, 4'h0, 1'b1);
    attr(3'h2, 3'b100, 4'h2, 1'b0, 4'h0, 1'b0);
    attr(3'h5, 3'b100, 4'h4, 1'b1, 4'h1, 1'b1);
    attr(3'h6, 3'b011, 4'h4, 1'b0, 4'he, 1'b1);
    attr(3'h7, 3'b010, 4'h4, 1'b0, 4'hb, 1'b1);
    // Overlap: the highest enabled region decides, then the next one
    wr(OFF_FAULT_STATUS, 32'hf, RESP_OKAY);
    cfg(3'h5, aword(PERM_NONE, 3'h0, 3'b010));
    cfg(3'h2, aword(PERM_FULL, 3'h0, 3'b010));
    acc(1'b1, 1'b0, 8'h25, 1'b1, 3'h5);
    rd(OFF_FAULT_STATUS, 32'h0000_0501, RESP_OKAY);
    chk("irq", 32'h0, 32'(irq));
    wr(OFF_IRQ_MASK, 32'h1, RESP_OKAY);
    #1;
    chk("irq", 32'h1, 32'(irq));
    wr(OFF_FAULT_STATUS, 32'h1, RESP_OKAY);
    #1;
    chk("irq", 32'h0, 32'(irq));
    cfg(3'h5, 32'h0);
    acc(1'b1, 1'b0, 8'h25, 1'b0, 3'h2);
    chk("resp_hit", 32'h1, 32'(resp_hit));
    cfg(3'h7, aword(PERM_FULL, 3'h0, 3'b010));
    acc(1'b0, 1'b0, 8'hff, 1'b0, 3'h7);
    // No enabled hit: privileged passes, unprivileged is stopped
    acc(1'b1, 1'b1, 8'h00, 1'b0, 3'h0);
    chk("resp_hit", 32'h0, 32'(resp_hit));
    acc(1'b0, 1'b1, 8'h00, 1'b1, 3'h0);
    rd(OFF_FAULT_STATUS, 32'h0000_000e, RESP_OKAY);
    wrap_up();
  end
endmodule

// ==== verilog/attr_decode.sv ====
// Purpose: Decode type extension, S, C and B into memory type and policy
// Assumes: Purely combinational, fed from the highest enabled hit region
// Notes: Results are informational only on a cacheless single core
module attr_decode
  import mpu_pkg::*;
(
  input wire logic [2:0] type_extension_field,
  input wire logic s_bit,
  input wire logic c_bit,
  input wire logic b_bit,
  output mem_type_e mem_type,
  output logic shareable,
  output logic [1:0] inner_policy_bits,
  output logic [1:0] outer_policy_bits
);
  // Inner policy comes straight from C,B for extension 000 with C=1 and for top-bit encodings
  wire logic [1:0] cb = {c_bit, b_bit};
  wire logic ext_top = type_extension_field[2];
  wire logic ext0 = (type_extension_field == 3'h0);
  wire logic ext1 = (type_extension_field == 3'h1);
  wire logic ext2 = (type_extension_field == 3'h2);
  wire logic is_strong = ext0 && (cb == 2'h0);
  wire logic is_dev0 = ext0 && (cb == 2'h1);
  wire logic is_norm0 = ext0 && c_bit;
  wire logic is_nc1 = ext1 && (cb == 2'h0);
  wire logic is_wb1 = ext1 && (cb == 2'h3);
  wire logic is_dev2 = ext2 && (cb == 2'h0);
  wire logic is_normal = ext_top || is_norm0 || is_nc1 || is_wb1;

  // Memory type; anything not listed is reserved
  assign mem_type = is_strong ? MT_STRONG :
                    (is_dev0 || is_dev2) ? MT_DEVICE :
                    is_normal ? MT_NORMAL : MT_RESERVED;
  // S is ignored for strongly ordered and device encodings
  assign shareable = (is_strong || is_dev0) ? 1'b1 :
                     is_normal ? s_bit : 1'b0;
  // Policy codes share one table for inner and outer
  assign inner_policy_bits = ext_top ? cb :
                             is_norm0 ? cb :
                             is_wb1 ? POL_WB_ALLOC : POL_NONCACHE;
  assign outer_policy_bits = ext_top ? type_extension_field[1:0] :
                             is_norm0 ? cb :
                             is_wb1 ? POL_WB_ALLOC : POL_NONCACHE;
endmodule

// ==== verilog/mpu_attr_check.sv ====
// Purpose: Region attribute table, access check and fault reporting
// Assumes: Address matching outside gives a per-region hit vector
// Notes: One access answered per cycle, one cycle after it is presented
module mpu_attr_check
  import mpu_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic acc_valid,
  input wire logic acc_priv,
  input wire logic acc_write,
  input wire logic [NUM_REGIONS-1:0] acc_region_hit,
  output logic resp_valid,
  output logic resp_fault,
  output logic resp_hit,
  output logic [2:0] resp_region,
  output mem_type_e resp_mem_type,
  output logic resp_shareable,
  output logic [1:0] resp_inner_policy,
  output logic [1:0] resp_outer_policy,
  output logic mm_fault_exc,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic prot_enable_r;
  logic [2:0] region_sel_r;
  logic [NUM_REGIONS-1:0] region_en_r;
  logic [2:0] type_extension_field_r [NUM_REGIONS];
  logic [2:0] access_permission_field_r [NUM_REGIONS];
  logic [NUM_REGIONS-1:0] s_r;
  logic [NUM_REGIONS-1:0] c_r;
  logic [NUM_REGIONS-1:0] b_r;
  logic [FS_EVENTS-1:0] memory_fault_status_reg;
  logic [FS_EVENTS-1:0] fault_status_nxt;
  logic [2:0] fault_region_r;
  logic [FS_EVENTS-1:0] irq_mask_r;

  // Write and read channel state
  logic aw_got_r;
  logic w_got_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  ////////////////////////////////////////////////////////////////////////
  // Write decode; address and data may arrive in either order
  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic w_take = s_axi_wvalid && s_axi_wready;
  wire logic do_write = aw_got_r && w_got_r && !bvalid_r;
  wire logic wr_ctrl = do_write && (awaddr_r == OFF_CTRL);
  wire logic wr_sel = do_write && (awaddr_r == OFF_REGION_SEL);
  wire logic wr_attr = do_write && (awaddr_r == OFF_REGION_ATTR);
  wire logic wr_fs = do_write && (awaddr_r == OFF_FAULT_STATUS);
  wire logic wr_mask = do_write && (awaddr_r == OFF_IRQ_MASK);
  wire logic wr_hit = wr_ctrl || wr_sel || wr_attr || wr_fs || wr_mask;
  // Fields live in bytes 0, 2 and 3, so each lane is honoured separately
  wire logic lane0 = wstrb_r[0];
  wire logic lane2 = wstrb_r[2];
  wire logic lane3 = wstrb_r[3];

  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready = !w_got_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // Hold address and data until both are in, then answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= RESET_VALUE;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? RESP_OKAY : RESP_DECERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control, selection and mask registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prot_enable_r <= 1'b0;
      region_sel_r <= 3'h0;
      irq_mask_r <= '0;
    end else begin
      if (wr_ctrl && lane0) prot_enable_r <= wdata_r[0];
      if (wr_sel && lane0) region_sel_r <= wdata_r[2:0];
      if (wr_mask && lane0) irq_mask_r <= wdata_r[FS_EVENTS-1:0];
    end
  end

  // One attribute slot per region, written through the selector
  for (genvar i = 0; i < NUM_REGIONS; i++) begin : g_region
    wire logic wr_me = wr_attr && (region_sel_r == 3'(i));
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        region_en_r[i] <= 1'b0;
        b_r[i] <= 1'b0;
        c_r[i] <= 1'b0;
        s_r[i] <= 1'b0;
        type_extension_field_r[i] <= 3'h0;
        access_permission_field_r[i] <= PERM_NONE;
      end else if (wr_me) begin
        if (lane0) region_en_r[i] <= wdata_r[ATTR_EN_BIT];
        if (lane2) begin
          b_r[i] <= wdata_r[ATTR_B_BIT];
          c_r[i] <= wdata_r[ATTR_C_BIT];
          s_r[i] <= wdata_r[ATTR_S_BIT];
          type_extension_field_r[i] <= wdata_r[ATTR_TYPE_LSB +: 3];
        end
        if (lane3) begin
          access_permission_field_r[i] <= wdata_r[ATTR_PERM_LSB +: 3];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read side; one read outstanding, answered the cycle after it is taken
  wire logic ar_take = s_axi_arvalid && s_axi_arready;
  wire logic [2:0] rs = region_sel_r;
  wire logic [31:0] attr_word = {5'h0, access_permission_field_r[rs],
    2'h0, type_extension_field_r[rs], s_r[rs], c_r[rs], b_r[rs],
    15'h0, region_en_r[rs]};
  wire logic [31:0] fs_word = {21'h0, fault_region_r, 4'h0,
    memory_fault_status_reg};
  wire logic [31:0] rd_mux =
    (s_axi_araddr == OFF_CTRL) ? {31'h0, prot_enable_r} :
    (s_axi_araddr == OFF_REGION_SEL) ? {29'h0, region_sel_r} :
    (s_axi_araddr == OFF_REGION_ATTR) ? attr_word :
    (s_axi_araddr == OFF_FAULT_STATUS) ? fs_word :
    (s_axi_araddr == OFF_IRQ_MASK) ? {28'h0, irq_mask_r} : 32'h0;
  wire logic rd_hit = (s_axi_araddr == OFF_CTRL) ||
    (s_axi_araddr == OFF_REGION_SEL) || (s_axi_araddr == OFF_REGION_ATTR) ||
    (s_axi_araddr == OFF_FAULT_STATUS) || (s_axi_araddr == OFF_IRQ_MASK);

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= RESET_VALUE;
      rresp_r <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Region priority: scan upward so the highest enabled hit is kept
  function automatic logic [2:0] pick_top(
    input logic [NUM_REGIONS-1:0] hits
  );
    logic [2:0] idx;
    idx = 3'h0;
    for (int k = 0; k < NUM_REGIONS; k++) begin
      if (hits[k]) idx = 3'(k);
    end
    return idx;
  endfunction

  wire logic [NUM_REGIONS-1:0] live_hits = acc_region_hit & region_en_r;
  wire logic any_hit = |live_hits;
  wire logic [2:0] top = pick_top(live_hits);
  wire logic perm_fault;
  wire mem_type_e dec_type;
  wire logic dec_share;
  wire logic [1:0] dec_inner;
  wire logic [1:0] dec_outer;

  attr_decode u_decode (
    .type_extension_field(type_extension_field_r[top]),
    .s_bit(s_r[top]),
    .c_bit(c_r[top]),
    .b_bit(b_r[top]),
    .mem_type(dec_type),
    .shareable(dec_share),
    .inner_policy_bits(dec_inner),
    .outer_policy_bits(dec_outer)
  );

  perm_check u_perm (
    .access_permission_field(access_permission_field_r[top]),
    .priv(acc_priv),
    .write(acc_write),
    .fault(perm_fault)
  );

  // Outside every region only privileged code may pass
  wire logic bg_fault = !any_hit && !acc_priv;
  wire logic chk_fault = prot_enable_r &&
                         (any_hit ? perm_fault : bg_fault);
  wire logic new_fault = acc_valid && chk_fault;

  ////////////////////////////////////////////////////////////////////////
  // Access answer, registered; attributes are reported but never gate
  // the access, since there is no cache to act on them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resp_valid <= 1'b0;
      resp_fault <= 1'b0;
      resp_hit <= 1'b0;
      resp_region <= 3'h0;
      resp_mem_type <= MT_NORMAL;
      resp_shareable <= 1'b0;
      resp_inner_policy <= POL_NONCACHE;
      resp_outer_policy <= POL_NONCACHE;
      mm_fault_exc <= 1'b0;
    end else begin
      resp_valid <= acc_valid;
      resp_fault <= new_fault;
      mm_fault_exc <= new_fault;
      if (acc_valid) begin
        resp_hit <= any_hit;
        resp_region <= top;
        // Background accesses report plain normal memory
        resp_mem_type <= any_hit ? dec_type : MT_NORMAL;
        resp_shareable <= any_hit && dec_share;
        resp_inner_policy <= any_hit ? dec_inner : POL_NONCACHE;
        resp_outer_policy <= any_hit ? dec_outer : POL_NONCACHE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fault cause capture; a new cause wins over a clearing write
  wire logic [FS_EVENTS-1:0] fs_set = {
    new_fault && !any_hit, new_fault && !acc_priv,
    new_fault && acc_write, new_fault && !acc_write};
  wire logic [FS_EVENTS-1:0] fs_clr =
    (wr_fs && lane0) ? wdata_r[FS_EVENTS-1:0] : '0;

  assign fault_status_nxt = (memory_fault_status_reg & ~fs_clr) | fs_set;
  assign irq = |(memory_fault_status_reg & irq_mask_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      memory_fault_status_reg <= '0;
      fault_region_r <= 3'h0;
    end else begin
      memory_fault_status_reg <= fault_status_nxt;
      if (new_fault) fault_region_r <= top;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb_main @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wire logic [2:0] cur_perm = access_permission_field_r[top];
  wire logic chk_on = acc_valid && prot_enable_r && any_hit;

  a_fault_exc: assert property (
    resp_fault |-> mm_fault_exc && resp_valid)
    else $error("Fault answer without exception pulse");
  a_no_access: assert property (
    chk_on && cur_perm == PERM_NONE |=> resp_fault)
    else $error("Permission 000 access not faulted");
  a_priv_only: assert property (
    chk_on && cur_perm == PERM_PRIV_RW |=> resp_fault == !$past(acc_priv))
    else $error("Privileged-only region judged wrongly");
  a_full_access: assert property (
    chk_on && cur_perm == PERM_FULL |=> !resp_fault)
    else $error("Full access region faulted");
  a_user_write: assert property (
    chk_on && cur_perm == PERM_USER_RO |=>
      resp_fault == ($past(acc_write) && !$past(acc_priv)))
    else $error("User read-only region judged wrongly");
  a_priv_read: assert property (
    chk_on && cur_perm == PERM_PRIV_RO |=>
      resp_fault ==
        ($past(acc_write) || !$past(acc_priv)))
    else $error("Privileged read-only region judged wrongly");
  a_read_only: assert property (
    chk_on && cur_perm[2:1] == 2'h3 |=> resp_fault == $past(acc_write))
    else $error("Read-only region judged wrongly");
  a_cause_kept: assert property (
    new_fault && !acc_write |=> memory_fault_status_reg[FS_READ_BIT]
      ##1 (memory_fault_status_reg[FS_READ_BIT] || $past(wr_fs)))
    else $error("Fault cause not recorded");
  a_top_region: assert property (
    acc_valid && acc_region_hit[7] && region_en_r[7] |=> resp_region == 3'h7)
    else $error("Highest region did not win");
  a_strong_ord: assert property (
    acc_valid && any_hit && type_extension_field_r[top] == 3'h0 &&
      !c_r[top] && !b_r[top]
      |=> resp_mem_type == MT_STRONG && resp_shareable)
    else $error("Strongly ordered decode wrong");

  c_fault_seen: cover property (resp_fault ##1 irq);
  c_pass_normal: cover property (
    resp_valid && !resp_fault && resp_mem_type == MT_NORMAL);
  c_overlap: cover property (acc_valid && $countones(live_hits) > 1);
endmodule

// ==== verilog/mpu_pkg.sv ====
// Purpose: Shared constants for the region attribute and permission checker
// Assumes: AXI4-Lite register access, 32-bit data, one clock
// Notes: Offsets are byte addresses on the register bus
//
// Overview of operation
// - An access forbidden by the region permissions gives a fault.
// - Extension 000, C=B=0 strongly ordered; B=1 device; both shareable.
// - Extension 000, C=1 normal, sharing from S; B=0 write-through.
// - Extension 001, C=B=1 normal write-back read/write allocate.
// - Extension top bit set: normal, outer from low bits, inner C,B.
// - Policy 00 none, 01 WB allocate, 10 WT, 11 WB no allocate.
// - Permission 000 faults every access.
// - Permission 001 privileged only; 011 full access.
// - Permission 010 faults only unprivileged writes.
// - Permission 101 allows privileged reads only.
// - Permission 110 and 111 are read-only for both levels.
// - A violation raises the memory management fault exception.
// - The fault cause is recorded in a readable fault status register.
// - Decoded cache and share attributes do not steer any behaviour.
// - Overlapping regions 0-7: highest numbered enabled hit wins.
package mpu_pkg;
  localparam int ADDR_W = 8;
  localparam int NUM_REGIONS = 8;
  // Register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_REGION_SEL = 8'h04;
  localparam logic [7:0] OFF_REGION_ATTR = 8'h08;
  localparam logic [7:0] OFF_FAULT_STATUS = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  // Attribute register field positions
  localparam int ATTR_EN_BIT = 0;
  localparam int ATTR_B_BIT = 16;
  localparam int ATTR_C_BIT = 17;
  localparam int ATTR_S_BIT = 18;
  localparam int ATTR_TYPE_LSB = 19;
  localparam int ATTR_PERM_LSB = 24;
  // Fault status fields
  localparam int FS_READ_BIT = 0;
  localparam int FS_WRITE_BIT = 1;
  localparam int FS_UNPRIV_BIT = 2;
  localparam int FS_NOREGION_BIT = 3;
  localparam int FS_REGION_LSB = 8;
  localparam int FS_EVENTS = 4;
  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Cache policy codes
  localparam logic [1:0] POL_NONCACHE = 2'h0;
  localparam logic [1:0] POL_WB_ALLOC = 2'h1;
  localparam logic [1:0] POL_WT = 2'h2;
  localparam logic [1:0] POL_WB_NOALLOC = 2'h3;
  // Permission codes
  localparam logic [2:0] PERM_NONE = 3'h0;
  localparam logic [2:0] PERM_PRIV_RW = 3'h1;
  localparam logic [2:0] PERM_USER_RO = 3'h2;
  localparam logic [2:0] PERM_FULL = 3'h3;
  localparam logic [2:0] PERM_RESERVED = 3'h4;
  localparam logic [2:0] PERM_PRIV_RO = 3'h5;
  localparam logic [2:0] PERM_RO_A = 3'h6;
  localparam logic [2:0] PERM_RO_B = 3'h7;
  typedef enum logic [3:0] {
    MT_STRONG = 4'h1,
    MT_DEVICE = 4'h2,
    MT_NORMAL = 4'h4,
    MT_RESERVED = 4'h8
  } mem_type_e;
endpackage

// ==== verilog/perm_check.sv ====
// Purpose: Judge one access against a region permission code
// Assumes: Purely combinational
// Notes: The reserved code is treated as no access, the safe choice
module perm_check
  import mpu_pkg::*;
(
  input wire logic [2:0] access_permission_field,
  input wire logic priv,
  input wire logic write,
  output logic fault
);
  // One fault term per permission code except 011; 110 and 111 share f_ro
  wire logic f_none = (access_permission_field == PERM_NONE);
  wire logic f_priv = (access_permission_field == PERM_PRIV_RW) &&
                      !priv;
  wire logic f_user = (access_permission_field == PERM_USER_RO) && !priv &&
                      write;
  wire logic f_rsvd = (access_permission_field == PERM_RESERVED);
  wire logic f_pro = (access_permission_field == PERM_PRIV_RO) &&
                     (write || !priv);
  wire logic f_ro = ((access_permission_field == PERM_RO_A) ||
                     (access_permission_field == PERM_RO_B)) && write;

  // Code 011 contributes no term: full access
  assign fault = f_none || f_priv || f_user || f_rsvd || f_pro || f_ro;
endmodule
